// ==== core/pcl_pwm_cycle_config.v ====
// Functional notes
// RULE_01: Bank bit steers compare addresses to reload.
// RULE_02: Reload values matter only in 9-11 bit PWM.
// RULE_03: Flag and mask request the shared interrupt.
// RULE_04: Set flag on overflow of selected bit.
// RULE_05: Flag sticky; software clears, write one sets.
// RULE_06: Bits four to two read zero.
// RULE_07: Length field 00..11 gives 8..11 bits.
// RULE_08: Length applies only to narrow PWM channels.
// RULE_09: Wide select picks 16-bit PWM per module.
// RULE_10: Copy reload into compare at cycle wrap.
`timescale 1ns/1ps
`default_nettype none
`include "pcl_defs.vh"
module pcl_pwm_cycle_config (
	input  wire        clk_sys,
	input  wire        srst,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire [15:0] main_array_counter,
	input  wire        counter_tick,
	input  wire [5:0]  wide_pwm_select,
	input  wire [5:0]  pwm_enable,
	output reg  [95:0] module_compare_value,
	output reg  [1:0]  cycle_length_select,
	output reg  [5:0]  narrow_pwm_active,
	output reg         cycle_wrap_flag,
	output reg         cycle_irq_req
);
	// Configuration bits held apart; the unused middle bits have no storage at all.
	reg                          reload_bank_select;
	reg                          cycle_wrap_irq_mask;
	// One reload word per module; software reaches it only through the bank bit.
	reg  [15:0]                  reload_value [0:`PCL_NUM_MOD-1];
	reg  [7:0]                   next_rdata;
	reg                          wrap_event;
	reg                          cfg_wr;
	reg                          flag_write_one;
	// Next compare words of all modules, gathered by the generate loop below.
	wire [`PCL_NUM_MOD*16-1:0]   next_compare;
	// Read bytes of the modules, OR-ed together stage by stage; at most one hits.
	wire [`PCL_NUM_MOD*8+7:0]    rd_chain;
	// Modules in narrow PWM now, and whether the cycle is longer than 8 bits.
	wire [`PCL_NUM_MOD-1:0]      narrow_now;
	wire                         long_cycle;
	genvar                       g;

	// Carry out of the selected bit: counter ticks while that bit and all bits below are ones.
	function wrap_at;
		input [15:0] cnt;
		input [1:0]  sel;
		begin
			case (sel)
				`PCL_LEN_8BIT: wrap_at = &cnt[7:0];
				`PCL_LEN_9BIT: wrap_at = &cnt[8:0];
				`PCL_LEN_10BIT: wrap_at = &cnt[9:0];
				default: wrap_at = &cnt[10:0];
			endcase
		end
	endfunction

	// Byte address decode of one module, used by both the write and the read path.
	// Module n sits two addresses above module n-1, low byte first.
	function byte_hit;
		input [7:0] addr;
		input [7:0] base;
		input [2:0] idx;
		begin
			byte_hit = (addr == base + {4'h0, idx, 1'h0});
		end
	endfunction

	// Detect the overflow one step before the counter rolls, so the flag lands with it.
	always @* begin
		wrap_event = counter_tick & wrap_at(main_array_counter, cycle_length_select); // [RULE_04] [RULE_07]
		cfg_wr = reg_wr & (reg_addr == `PCL_CFG_ADDR);
		flag_write_one = cfg_wr & reg_wdata[`PCL_BIT_FLAG];
	end

	// Configuration register writes; middle bits are simply dropped.
	// Dropping them at the write keeps the read-back zero without extra gating.
	always @(posedge clk_sys) begin
		if (srst) begin
			reload_bank_select <= 1'h0;
			cycle_wrap_irq_mask <= 1'h0;
			cycle_length_select <= 2'h0;
		end else if (cfg_wr) begin
			reload_bank_select <= reg_wdata[`PCL_BIT_BANK];
			cycle_wrap_irq_mask <= reg_wdata[`PCL_BIT_MASK];
			cycle_length_select <= reg_wdata[`PCL_CLSEL_HI:`PCL_CLSEL_LO]; // [RULE_06]
		end
	end

	// Sticky flag: a hardware event wins over a same-cycle software clear.
	// Losing the event would hide a whole PWM cycle from software.
	always @(posedge clk_sys) begin
		if (srst) begin
			cycle_wrap_flag <= 1'h0;
		end else if (wrap_event | flag_write_one) begin
			cycle_wrap_flag <= 1'h1; // [RULE_05] [RULE_04]
		end else if (cfg_wr) begin
			cycle_wrap_flag <= 1'h0; // [RULE_05]
		end
	end

	// Interrupt request is registered from the flag and mask of the previous cycle.
	// The extra cycle of latency buys a glitch-free request straight from a flop.
	always @(posedge clk_sys) begin
		if (srst) begin
			cycle_irq_req <= 1'h0;
		end else begin
			cycle_irq_req <= cycle_wrap_flag & cycle_wrap_irq_mask; // [RULE_03]
		end
	end

	// Channels in narrow PWM use the shared length; wide ones ignore it.
	always @(posedge clk_sys) begin
		if (srst) begin
			narrow_pwm_active <= 6'h00;
		end else begin
			narrow_pwm_active <= pwm_enable & ~wide_pwm_select; // [RULE_08] [RULE_09]
		end
	end

	// Stage zero of the read chain; each module ORs its byte in after it.
	assign rd_chain[7:0] = 8'h00;
	// Reload copies only happen for narrow PWM longer than 8 bits, so in any other
	// mode the reload bank is inert storage and software may park anything there.
	assign narrow_now = pwm_enable & ~wide_pwm_select; // [RULE_08] [RULE_09]
	assign long_cycle = (cycle_length_select != `PCL_LEN_8BIT); // [RULE_02]

	// One slice per capture/compare module: address hits, reload storage,
	// next compare word and read byte. Compare and reload share byte addresses,
	// and the bank bit alone decides which of the two a bus access reaches.
	generate
		for (g = 0; g < `PCL_NUM_MOD; g = g + 1) begin : g_mod
			localparam integer IDX = g;
			wire        hit_low;
			wire        hit_high;
			wire        load_reload;
			reg  [7:0]  rbyte;
			reg  [15:0] next_cmp;

			// Byte decode, shared by the write path and the read path.
			assign hit_low = byte_hit(reg_addr, `PCL_CMP_LOW_BASE, IDX[2:0]); // [RULE_01]
			assign hit_high = byte_hit(reg_addr, `PCL_CMP_HIGH_BASE, IDX[2:0]); // [RULE_01]
			// The copy waits for the cycle wrap so a duty change never splits a cycle.
			assign load_reload = wrap_event & long_cycle & narrow_now[g]; // [RULE_10] [RULE_02]

			// Reload word: written only while the bank bit points at it.
			always @(posedge clk_sys) begin
				if (srst) begin
					reload_value[g] <= `PCL_WORD_RESET;
				end else if (reg_wr & reload_bank_select) begin
					if (hit_low) begin
						reload_value[g][7:0] <= reg_wdata; // [RULE_01]
					end else if (hit_high) begin
						reload_value[g][15:8] <= reg_wdata; // [RULE_01]
					end
				end
			end

			// A software write in the same cycle as a reload copy wins for its byte.
			always @* begin
				next_cmp = module_compare_value[g*16 +: 16];
				if (load_reload) begin
					next_cmp = reload_value[g]; // [RULE_10]
				end
				if (reg_wr & ~reload_bank_select & hit_low) begin
					next_cmp[7:0] = reg_wdata; // [RULE_01]
				end
				if (reg_wr & ~reload_bank_select & hit_high) begin
					next_cmp[15:8] = reg_wdata; // [RULE_01]
				end
			end
			assign next_compare[g*16 +: 16] = next_cmp;

			// Read byte of this module, zero unless the address is one of its two.
			always @* begin
				rbyte = 8'h00;
				if (hit_low) begin
					rbyte = reload_bank_select ? reload_value[g][7:0]
						: module_compare_value[g*16 +: 8]; // [RULE_01]
				end else if (hit_high) begin
					rbyte = reload_bank_select ? reload_value[g][15:8]
						: module_compare_value[g*16+8 +: 8]; // [RULE_01]
				end
			end
			assign rd_chain[g*8+8 +: 8] = rd_chain[g*8 +: 8] | rbyte;
		end
	endgenerate

	// Active compare words; everything that moves them is folded into next_compare.
	always @(posedge clk_sys) begin
		if (srst) begin
			module_compare_value <= {`PCL_NUM_MOD{`PCL_WORD_RESET}};
		end else begin
			module_compare_value <= next_compare;
		end
	end

	// Read mux; unmapped addresses return zero because no stage of the chain hits.
	always @* begin
		next_rdata = 8'h00;
		if (reg_addr == `PCL_CFG_ADDR) begin
			next_rdata = {reload_bank_select, cycle_wrap_irq_mask, cycle_wrap_flag,
				3'h0, cycle_length_select}; // [RULE_06]
		end else begin
			next_rdata = rd_chain[`PCL_NUM_MOD*8 +: 8]; // [RULE_01]
		end
	end

	// Read data is registered; it is valid the cycle after reg_rd.
	// It holds between reads, so a slow bus master may pick it up late.
	always @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// ==== core/pcl_defs.vh ====
`ifndef PCL_DEFS_VH
`define PCL_DEFS_VH
// Register address of the shared PWM cycle configuration register.
`define PCL_CFG_ADDR 8'hDF
// Compare low/high byte addresses of module 0; module n sits at base plus 2n.
`define PCL_CMP_LOW_BASE 8'hE9
`define PCL_CMP_HIGH_BASE 8'hEA
// Field positions in the configuration register.
`define PCL_BIT_BANK 7
`define PCL_BIT_MASK 6
`define PCL_BIT_FLAG 5
`define PCL_CLSEL_HI 1
`define PCL_CLSEL_LO 0
// Cycle length codes of the length field.
`define PCL_LEN_8BIT 2'h0
`define PCL_LEN_9BIT 2'h1
`define PCL_LEN_10BIT 2'h2
`define PCL_LEN_11BIT 2'h3
// Reset values.
`define PCL_CFG_RESET 8'h00
`define PCL_WORD_RESET 16'h0000
// Number of capture/compare modules.
`define PCL_NUM_MOD 6
`endif

// ==== verif/pcl_pwm_cycle_config_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcl_pwm_cycle_config_monitor (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic [15:0] main_array_counter,
	input wire logic        counter_tick,
	input wire logic [5:0]  wide_pwm_select,
	input wire logic [5:0]  pwm_enable,
	input wire logic [1:0]  cycle_length_select,
	input wire logic [5:0]  narrow_pwm_active,
	input wire logic        cycle_wrap_flag,
	input wire logic        cycle_irq_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Config writes are the only software path that may move the flag or length.
	wire cfg_wr = reg_wr && reg_addr == 8'hDF;
	AST_IRQ_OFF: assert property (!$past(cycle_wrap_flag) |-> !cycle_irq_req) else $error("irq");
	AST_STICKY: assert property (cycle_wrap_flag && !cfg_wr |=> cycle_wrap_flag) else $error("sticky");
	AST_SW_SET: assert property (cfg_wr && reg_wdata[5] |=> cycle_wrap_flag) else $error("set");
	AST_LEN: assert property (cfg_wr |=> cycle_length_select == $past(reg_wdata[1:0])) else $error("len");
	AST_LEN_HOLD: assert property (!cfg_wr |=> $stable(cycle_length_select)) else $error("hold");
	AST_WRAP: assert property (counter_tick &&
		&(main_array_counter | ~(16'h07FF >> (2'h3 - cycle_length_select)))
		|=> cycle_wrap_flag) else $error("wrap");
	AST_NO_WRAP: assert property (!cycle_wrap_flag && !counter_tick && !cfg_wr |=> !cycle_wrap_flag) else $error("spurious");
	AST_NARROW: assert property (!$past(srst) |->
		narrow_pwm_active == $past(pwm_enable & ~wide_pwm_select)) else $error("narrow");
	AST_PAD: assert property (reg_rd && reg_addr == 8'hDF |=> reg_rdata[4:2] == 3'h0) else $error("pad");
endmodule
`default_nettype wire

// ==== verif/pcl_pwm_cycle_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcl_pwm_cycle_config_bench;
	logic        clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, counter_tick = 0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [15:0] main_array_counter = 16'h0000;
	logic [5:0]  wide_pwm_select = 6'h00, pwm_enable = 6'h00, narrow_pwm_active;
	wire  [7:0]  reg_rdata;
	wire  [95:0] module_compare_value;
	wire  [1:0]  cycle_length_select;
	wire         cycle_wrap_flag, cycle_irq_req;
	int          n_fail = 0, checked = 0;
	pcl_pwm_cycle_config u_dut (
		.clk_sys              (clk_sys),
		.srst                 (srst),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.main_array_counter   (main_array_counter),
		.counter_tick         (counter_tick),
		.wide_pwm_select      (wide_pwm_select),
		.pwm_enable           (pwm_enable),
		.module_compare_value (module_compare_value),
		.cycle_length_select  (cycle_length_select),
		.narrow_pwm_active    (narrow_pwm_active),
		.cycle_wrap_flag      (cycle_wrap_flag),
		.cycle_irq_req        (cycle_irq_req)
	);
	// Free-running system clock.
	initial forever #10 clk_sys = ~clk_sys;
	task chk(input string nm, input [15:0] s, e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Bus tasks start and end 1 ns after an edge, so strobes never race the clock.
	task wr(input [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clk_sys) #1;
		reg_wr = 0;
	endtask
	task rd(input [7:0] a, e);
		reg_addr = a;
		reg_rd = 1;
		@(posedge clk_sys) #1;
		reg_rd = 0;
		chk("rdata", reg_rdata, e);
	endtask
	task tick(input [15:0] v);
		main_array_counter = v;
		counter_tick = 1;
		@(posedge clk_sys) #1;
		counter_tick = 0;
	endtask
	task report_and_stop;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence; every wait is a fixed count taken from the hand-over timing.
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 srst = 0;
		rd(8'hDF, 8'h00);
		wr(8'hDF, 8'hFF);
		rd(8'hDF, 8'hE3);
		chk("irq", cycle_irq_req, 1);
		wr(8'hDF, 8'h01);
		rd(8'hDF, 8'h01);
		chk("irq", cycle_irq_req, 0);
		for (int s = 0; s < 4; s++) begin
			wr(8'hDF, 8'(s));
			tick(16'h07FF >> (4 - s));
			chk("flag", cycle_wrap_flag, 0);
			tick(16'h07FF >> (3 - s));
			chk("flag", cycle_wrap_flag, 1);
			chk("len", cycle_length_select, 16'(s));
		end
		wr(8'hE9, 8'h34);
		chk("irq", cycle_irq_req, 0);
		chk("flag", cycle_wrap_flag, 1);
		wr(8'hEA, 8'h12);
		wr(8'hDF, 8'h81);
		wr(8'hE9, 8'h56);
		wr(8'hEA, 8'h78);
		wr(8'hEB, 8'h11);
		chk("cmp0", module_compare_value[15:0], 16'h1234);
		pwm_enable = 6'h03;
		wide_pwm_select = 6'h02;
		tick(16'h01FF);
		chk("cmp0", module_compare_value[15:0], 16'h7856);
		chk("cmp1", module_compare_value[31:16], 16'h0000);
		chk("narrow", narrow_pwm_active, 6'h01);
		wr(8'hDF, 8'h80);
		wr(8'hE9, 8'h9A);
		tick(16'h00FF);
		chk("cmp0", module_compare_value[15:0], 16'h7856);
		rd(8'hE9, 8'h9A);
		wr(8'hDF, 8'h00);
		rd(8'hE9, 8'h56);
		// A hardware wrap and a software clear in one cycle: the set wins.
		main_array_counter = 16'h00FF;
		counter_tick = 1;
		wr(8'hDF, 8'h40);
		counter_tick = 0;
		chk("flag", cycle_wrap_flag, 1);
		// A reset in mid-run returns every register and output to zero.
		srst = 1;
		repeat (2) @(posedge clk_sys);
		#1 srst = 0;
		chk("flag", cycle_wrap_flag, 0);
		chk("irq", cycle_irq_req, 0);
		chk("cmp0", module_compare_value[15:0], 16'h0000);
		rd(8'hDF, 8'h00);
		wr(8'hDF, 8'h80);
		rd(8'hE9, 8'h00);
		report_and_stop();
	end
endmodule
bind pcl_pwm_cycle_config pcl_pwm_cycle_config_monitor u_mon (
	.clk_sys             (clk_sys),
	.srst                (srst),
	.reg_wr              (reg_wr),
	.reg_rd              (reg_rd),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_rdata           (reg_rdata),
	.main_array_counter  (main_array_counter),
	.counter_tick        (counter_tick),
	.wide_pwm_select     (wide_pwm_select),
	.pwm_enable          (pwm_enable),
	.cycle_length_select (cycle_length_select),
	.narrow_pwm_active   (narrow_pwm_active),
	.cycle_wrap_flag     (cycle_wrap_flag),
	.cycle_irq_req       (cycle_irq_req)
);
`default_nettype wire
